// *** src/hbridge_pkg.sv ***
/*
  Shared types and constants for the H-bridge input decoder with autosleep.
  Assumes a 25 MHz system clock; all times below are converted to cycles of it.
*/
package hbridge_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // Dead time between switching off one side and switching on the other
  localparam int unsigned T_DEAD_NS = 500;
  localparam logic [3:0] DEAD_CYCLES = 4'((T_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Idle interval before autosleep, shortest end of the 1 to 2 ms window
  localparam int unsigned T_SLEEP_NS = 1000000;
  localparam logic [15:0] SLEEP_CYCLES_DEF =
    16'((T_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Wake interval the inputs must stay active before the bridge drives again
  localparam int unsigned T_WAKE_NS = 100000;
  localparam logic [15:0] WAKE_CYCLES_DEF =
    16'((T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [3:0] DEAD_ZERO = 4'h0;

  typedef enum logic [1:0] {
    MODE_PWM = 2'b00,
    MODE_PHEN = 2'b01,
    MODE_HALF = 2'b10
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } power_state_t;

  // Tri-level selector as seen after the pad comparators
  typedef struct packed {
    logic is_high;
    logic is_floating;
  } mode_pin_t;

  // One half-bridge: both low means the output is high impedance
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } half_drive_t;

  localparam half_drive_t DRIVE_OFF = 2'b00;
  localparam half_drive_t DRIVE_LOW = 2'b01;
  localparam half_drive_t DRIVE_HIGH = 2'b10;

endpackage

// *** src/hbridge_input_decoder_autosleep.sv ***
/*
  H-bridge input decoder: selector decode, truth tables per mode, automatic
  dead time per half-bridge, and the idle timer that puts the bridge to sleep.
  Assumes all inputs are synchronous to sys_clk and that pad pulldowns
  already turn an unconnected control input into a logic low.
*/
`timescale 1ns/1ps

module hbridge_input_decoder_autosleep
  import hbridge_pkg::*;
#(
  parameter logic [15:0] SLEEP_CYCLES = SLEEP_CYCLES_DEF,
  parameter logic [15:0] WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reduced_pin_variant,
  input wire mode_pin_t mode_pin,
  input wire logic direction_or_input_a_pin,
  input wire logic gate_or_input_b_pin,
  output half_drive_t bridge_output_a,
  output half_drive_t bridge_output_b,
  output logic asleep
);

  ctrl_mode_t mode_sel;
  logic idle;
  half_drive_t want [2];
  half_drive_t drv_r [2];
  power_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;

  // Decoded every cycle from the live pin, so a change takes effect at once
  always_comb begin
    if (reduced_pin_variant) begin
      mode_sel = MODE_PWM;
    end else if (mode_pin.is_floating) begin
      mode_sel = MODE_HALF;
    end else if (mode_pin.is_high) begin
      mode_sel = MODE_PHEN;
    end else begin
      mode_sel = MODE_PWM;
    end
  end

  // Idle pattern per mode; half-bridge mode never idles while selected
  always_comb begin
    case (mode_sel)
      MODE_PWM: idle = !direction_or_input_a_pin && !gate_or_input_b_pin;
      MODE_PHEN: idle = !gate_or_input_b_pin;
      default: idle = 1'b0;
    endcase
  end

  // Requested state of each half before dead time and sleep are applied
  always_comb begin
    want[0] = DRIVE_OFF;
    want[1] = DRIVE_OFF;
    case (mode_sel)
      MODE_PWM: begin
        case ({direction_or_input_a_pin, gate_or_input_b_pin})
          2'b01: begin
            want[0] = DRIVE_LOW;
            want[1] = DRIVE_HIGH;
          end
          2'b10: begin
            want[0] = DRIVE_HIGH;
            want[1] = DRIVE_LOW;
          end
          2'b11: begin
            want[0] = DRIVE_LOW;
            want[1] = DRIVE_LOW;
          end
          default: begin
            want[0] = DRIVE_OFF;
            want[1] = DRIVE_OFF;
          end
        endcase
      end
      MODE_PHEN: begin
        if (!gate_or_input_b_pin) begin
          want[0] = DRIVE_LOW;
          want[1] = DRIVE_LOW;
        end else if (direction_or_input_a_pin) begin
          want[0] = DRIVE_HIGH;
          want[1] = DRIVE_LOW;
        end else begin
          want[0] = DRIVE_LOW;
          want[1] = DRIVE_HIGH;
        end
      end
      default: begin
        // A floating input reads low here, so its half drives low
        want[0] = direction_or_input_a_pin ? DRIVE_HIGH : DRIVE_LOW;
        want[1] = gate_or_input_b_pin ? DRIVE_HIGH : DRIVE_LOW;
      end
    endcase
  end

  // Power state: one counter serves as sleep timer and as wake timer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = CNT_ZERO;
    case (state_r)
      ST_ACTIVE: begin
        if (idle) begin
          if (cnt_r >= SLEEP_CYCLES - 16'h0001) begin
            state_nxt = ST_SLEEP;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
      end
      ST_SLEEP: begin
        if (!idle) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Any return to idle aborts the wake; the host must hold steady
        if (idle) begin
          state_nxt = ST_SLEEP;
        end else if (cnt_r >= WAKE_CYCLES - 16'h0001) begin
          state_nxt = ST_ACTIVE;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: begin
        state_nxt = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_ACTIVE;
      cnt_r <= CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign asleep = (state_r != ST_ACTIVE);

  // Dead time: a driven half always passes through off for DEAD_CYCLES + 1 cycles
  // before the opposite switch closes; turning off is never delayed.
  for (genvar h = 0; h < 2; h++) begin : g_half
    half_drive_t tgt;
    half_drive_t drv_nxt;
    logic [3:0] dead_r, dead_nxt;

    assign tgt = asleep ? DRIVE_OFF : want[h];

    always_comb begin
      drv_nxt = drv_r[h];
      dead_nxt = DEAD_ZERO;
      if (drv_r[h] != DRIVE_OFF) begin
        if (tgt != drv_r[h]) begin
          drv_nxt = DRIVE_OFF;
          dead_nxt = DEAD_CYCLES;
        end
      end else if (dead_r != DEAD_ZERO) begin
        dead_nxt = dead_r - 4'h1;
      end else begin
        drv_nxt = tgt;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        drv_r[h] <= DRIVE_OFF;
        dead_r <= DEAD_ZERO;
      end else begin
        drv_r[h] <= drv_nxt;
        dead_r <= dead_nxt;
      end
    end

    no_shoot_through_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n) !(drv_r[h].hs_on && drv_r[h].ls_on))
      else $error("both switches of a half-bridge on");

    dead_gap_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n) $fell(drv_r[h].ls_on) |-> !drv_r[h].hs_on [*8])
      else $error("high side closed too soon after low side");
  end

  assign bridge_output_a = drv_r[0];
  assign bridge_output_b = drv_r[1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_phen_brake_held;
    (mode_sel == MODE_PHEN && !gate_or_input_b_pin && !asleep) [*8] ##1
    (mode_sel == MODE_PHEN && !gate_or_input_b_pin && !asleep) [*8];
  endsequence

  sequence s_half_high_held;
    (mode_sel == MODE_HALF && direction_or_input_a_pin && !asleep) [*8] ##1
    (mode_sel == MODE_HALF && direction_or_input_a_pin && !asleep) [*8];
  endsequence

  // Checked on the registered outputs after 16 steady cycles, which covers a full swap
  logic phen_fwd_now;
  logic pwm_rev_now;
  assign phen_fwd_now = (mode_sel == MODE_PHEN) && gate_or_input_b_pin &&
    direction_or_input_a_pin && !asleep;
  assign pwm_rev_now = (mode_sel == MODE_PWM) && !direction_or_input_a_pin &&
    gate_or_input_b_pin && !asleep;

  sequence s_phen_fwd_held;
    phen_fwd_now [*8] ##1 phen_fwd_now [*8];
  endsequence

  sequence s_pwm_rev_held;
    pwm_rev_now [*8] ##1 pwm_rev_now [*8];
  endsequence

  variant_pwm_a: assert property (reduced_pin_variant |-> mode_sel == MODE_PWM)
    else $error("reduced-pin variant left PWM control");

  pwm_coast_a: assert property (
    (mode_sel == MODE_PWM && idle) |=> (drv_r[0] == DRIVE_OFF && drv_r[1] == DRIVE_OFF))
    else $error("PWM idle did not coast");

  sleep_entry_a: assert property (
    (state_r == ST_ACTIVE && idle && cnt_r == SLEEP_CYCLES - 16'h0001) |=> asleep)
    else $error("sleep not entered after idle interval");

  timer_restart_a: assert property ((state_r == ST_ACTIVE && !idle) |=> cnt_r == CNT_ZERO)
    else $error("idle timer not restarted");

  phen_brake_a: assert property (
    s_phen_brake_held |-> (drv_r[0] == DRIVE_LOW && drv_r[1] == DRIVE_LOW))
    else $error("gate low did not brake");

  sleep_hiz_a: assert property (
    asleep ##1 asleep |-> (drv_r[0] == DRIVE_OFF && drv_r[1] == DRIVE_OFF))
    else $error("outputs driven while asleep");

  phen_forward_a: assert property (
    s_phen_fwd_held |-> (drv_r[0] == DRIVE_HIGH && drv_r[1] == DRIVE_LOW))
    else $error("phase/enable forward not driven");

  half_follow_a: assert property (s_half_high_held |-> drv_r[0] == DRIVE_HIGH)
    else $error("half-bridge input high did not drive high side");

  pwm_reverse_a: assert property (
    s_pwm_rev_held |-> (drv_r[0] == DRIVE_LOW && drv_r[1] == DRIVE_HIGH))
    else $error("PWM reverse not driven");

endmodule

// *** tb/host_model.sv ***
/*
  Host controller model: drives the selector, the package strap and both control pins.
  Assumes the bench calls its tasks; every pin changes only at a falling edge of sys_clk.
*/
`timescale 1ns/1ps
module host_model
  import hbridge_pkg::*;
(
  input wire logic sys_clk,
  output logic variant,
  output mode_pin_t mode_pin,
  output logic pin_a,
  output logic pin_b
);
  initial begin
    variant = 1'b0;
    mode_pin = 2'h0;
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  task automatic set_variant(logic v);
    @(negedge sys_clk);
    variant = v;
  endtask

  task automatic drive(logic [1:0] m, logic a, logic b);
    @(negedge sys_clk);
    mode_pin = m;
    pin_a = a;
    pin_b = b;
  endtask

  // Levels stand untouched, so a wake request is held for its whole interval
  task automatic hold(int n);
    repeat (n - 1) @(negedge sys_clk);
  endtask

  // One PWM source on the gate only; direction stays a plain level
  task automatic pwm_gate(logic dir, int n);
    for (int i = 0; i < n; i++) begin
      drive(2'h2, dir, 1'($urandom));
    end
    drive(2'h2, dir, 1'b1);
  endtask
endmodule

// *** tb/testbench.sv ***
/*
  Self-checking bench for the H-bridge input decoder with short sleep and wake counts.
  Assumes the host model drives all inputs but clock and reset; notes are checked at falling edges.
*/
`timescale 1ns/1ps
module testbench;
  import hbridge_pkg::*;
  localparam logic [15:0] SLP = 16'h0028;
  localparam logic [15:0] WAK = 16'h000a;
  localparam int LIMIT = 4000;
  localparam logic [1:0] M_LO = 2'h0;
  localparam logic [1:0] M_HI = 2'h2;
  localparam logic [1:0] M_FL = 2'h1;
  localparam half_drive_t OF = DRIVE_OFF;
  localparam half_drive_t LO = DRIVE_LOW;
  localparam half_drive_t HI = DRIVE_HIGH;
  typedef struct {int at; logic [4:0] v;} note_t;
  logic sys_clk, rst_n, variant, pin_a, pin_b, asleep;
  mode_pin_t mode_pin;
  half_drive_t out_a, out_b;
  logic [4:0] pwm_tab [4] = '{{OF, OF, 1'b0}, {LO, HI, 1'b0}, {HI, LO, 1'b0}, {LO, LO, 1'b0}};
  logic [31:0] r;
  int cyc = 0;
  int fails = 0;
  int compares = 0;
  note_t q[$];

  host_model u_host(.sys_clk(sys_clk), .variant(variant), .mode_pin(mode_pin),
    .pin_a(pin_a), .pin_b(pin_b));
  hbridge_input_decoder_autosleep #(.SLEEP_CYCLES(SLP), .WAKE_CYCLES(WAK)) u_dut(
    .sys_clk(sys_clk), .rst_n(rst_n), .reduced_pin_variant(variant), .mode_pin(mode_pin),
    .direction_or_input_a_pin(pin_a), .gate_or_input_b_pin(pin_b),
    .bridge_output_a(out_a), .bridge_output_b(out_b), .asleep(asleep));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic check(logic [4:0] seen, logic [4:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    if (q.size() != 0) fails++;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watcher: a note is due once the cycle it names has been reached
  always @(negedge sys_clk) begin
    if (cyc > LIMIT) begin
      fails++;
      conclude();
    end
    while (q.size() > 0 && q[0].at <= cyc) begin
      check({out_a, out_b, asleep}, q[0].v);
      void'(q.pop_front());
    end
  end

  function automatic void exp(int k, logic [4:0] v);
    q.push_back('{cyc + k, v});
  endfunction

  task automatic step(logic [1:0] m, logic a, logic b, int k, logic [4:0] v, int w);
    u_host.drive(m, a, b);
    exp(k, v);
    u_host.hold(w);
  endtask

  // Idle from now on: still awake just before the interval, asleep and off after it
  task automatic doze(logic [1:0] m, logic a, logic b, logic [4:0] v);
    u_host.drive(m, a, b);
    exp(SLP - 2, v);
    exp(SLP + 3, {OF, OF, 1'b1});
    u_host.hold(SLP + 4);
  endtask

  task automatic wake(logic [1:0] m, logic a, logic [4:0] v);
    u_host.drive(m, a, 1'b1);
    exp(2, {OF, OF, 1'b1});
    exp(WAK + 16, v);
    u_host.hold(WAK + 17);
  endtask

  initial begin
    rst_n = 1'b0;
    void'($urandom(10));
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    exp(1, {OF, OF, 1'b0});
    for (int i = 0; i < 4; i++) begin
      step(M_LO, i[1], i[0], 16, pwm_tab[i], 17);
      step(M_LO, 1'b0, 1'b0, 2, {OF, OF, 1'b0}, 3);
    end
    $display("test pwm table done");
    // The coast just before leaves dead time pending, so forward waits out only the rest of the gap
    step(M_LO, 1'b1, 1'b0, 16, {HI, LO, 1'b0}, 17);
    u_host.drive(M_LO, 1'b0, 1'b1);
    exp(1, {OF, OF, 1'b0});
    exp(14, {OF, OF, 1'b0});
    exp(15, {LO, HI, 1'b0});
    u_host.hold(16);
    $display("test dead time done");
    step(M_LO, 1'b0, 1'b0, 1, {OF, OF, 1'b0}, 30);
    step(M_LO, 1'b1, 1'b0, 1, {HI, LO, 1'b0}, 1);
    doze(M_LO, 1'b0, 1'b0, {OF, OF, 1'b0});
    wake(M_LO, 1'b1, {LO, LO, 1'b0});
    $display("test autosleep done");
    step(M_HI, 1'b0, 1'b1, 16, {LO, HI, 1'b0}, 17);
    step(M_HI, 1'b1, 1'b1, 16, {HI, LO, 1'b0}, 17);
    u_host.pwm_gate(1'b1, 20);
    exp(16, {HI, LO, 1'b0});
    u_host.hold(17);
    r = $urandom;
    doze(M_HI, r[0], 1'b0, {LO, LO, 1'b0});
    wake(M_HI, r[0], r[0] ? {HI, LO, 1'b0} : {LO, HI, 1'b0});
    $display("test phase enable done");
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      step(r[2] ? 2'h3 : M_FL, r[0], r[1], 16, {r[0] ? HI : LO, r[1] ? HI : LO, 1'b0}, 17);
    end
    step(M_FL, 1'b0, 1'b0, SLP + 10, {LO, LO, 1'b0}, SLP + 11);
    u_host.drive(M_LO, 1'b0, 1'b0);
    exp(2, {OF, OF, 1'b0});
    u_host.hold(1);
    doze(M_LO, 1'b0, 1'b0, {OF, OF, 1'b0});
    wake(M_LO, 1'b1, {LO, LO, 1'b0});
    $display("test half bridge done");
    u_host.set_variant(1'b1);
    step(M_HI, 1'b1, 1'b1, 16, {LO, LO, 1'b0}, 17);
    step(M_FL, 1'b0, 1'b0, 16, {OF, OF, 1'b0}, 17);
    $display("test reduced pin done");
    // Let the watcher take the last note before the run ends
    repeat (2) @(negedge sys_clk);
    conclude();
  end
endmodule
